// *** dsfd_diag.sv ***
// fault filtering, latched diagnosis and sense selection for two channels
// assumes raw conditions and control inputs come asynchronously from pins
// and analog comparators; serial frame decoding lives outside this block.
// Contract
// - per channel, current-limit and overtemp flags merge into protective flag
// - per channel keep open-load, under-current and short-to-ground flags
// - short, load and first-limit faults count only after fault filtering time
// - status pin follows control input while no fault is recognised
// - recognised short or load fault makes status pin show the inverted control input
// - status indication is not latched; returns to following the input
// - recognised conditions latch into diagnosis flags until cleared
// - rising chip-select after a good transfer clears latched flags
// - overload at first limit keeps output on, status and fault low, code HL
// - overload past second limit beyond delay latches output off, code HL
// - short events are ignored; short ground LL or LH; load faults LH
// - autorestart overtemp: output off unfiltered, flag set, code HL
// - latching overtemp holds output off until input falling edge
// - sense source active for the selected channel only when enabled
// - sense source may follow the sum of both channels
// - latching overtemp flag clears on chip-select only once channel is off
// - in status-pin mode overtemp flag clears when condition goes
`timescale 1ns/100ps
`include "dsfd_defines.svh"

module dsfd_diag #(
  parameter logic [`DSFD_CNT_W-1:0] FAULT_CYC =
    `DSFD_CNT_W'(`DSFD_FAULT_CYC),
  parameter logic [`DSFD_CNT_W-1:0] OFF_SR1_CYC =
    `DSFD_CNT_W'(`DSFD_OFF_SR1_CYC),
  parameter logic [`DSFD_CNT_W-1:0] OFF_SR2_CYC =
    `DSFD_CNT_W'(`DSFD_OFF_SR2_CYC)
) (
  input wire logic clk_sys,              // 125 MHz system clock
  input wire logic arst_n,               // async reset, active low
  input wire logic [1:0] ctrl_in,        // channel control inputs, pins
  input wire dsfd_pkg::dsfd_cond_t [1:0] cond, // raw fault conditions
  input wire logic sleep,                // sleep mode request, pin
  input wire logic cs_n,                 // chip select, pin, active low
  input wire logic xfer_ok,              // current frame was well formed
  input wire logic [1:0] spi_off,        // serial turn-off per channel
  input wire logic [1:0] ot_latch_mode,  // 1: latching overtemp shutdown
  input wire logic [1:0] slew_sel,       // 1: slew rate 2 per channel
  input wire logic status_diag_mode,     // 1: diagnosis via status pins
  input wire logic sense_on,             // sense enable from serial
  input wire logic sense_ch,             // selected sense channel
  input wire logic sense_sum,            // sense the sum of both channels
  output logic [1:0] out_on,             // power output gate per channel
  output logic [1:0] channel_status_pin, // status pin per channel
  output logic fault_n,                  // shared fault pin, active low
  output dsfd_pkg::dsfd_flags_t [1:0] flags, // latched diagnosis flags
  output logic [3:0] diag_code,          // codes, ch1 in upper pair
  output logic sense_current_source,     // sense source active
  output logic [1:0] sense_mux           // channels summed into source
);

  dsfd_pkg::dsfd_state_t st;
  dsfd_pkg::dsfd_state_t next_st;
  // raw conditions pass three flops like other pins; three sync stages here
  dsfd_pkg::dsfd_cond_t [1:0] c_s1;
  dsfd_pkg::dsfd_cond_t [1:0] c_s2;
  dsfd_pkg::dsfd_cond_t [1:0] c_s3;

  // condition synchroniser; only stage two and three are compared
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      c_s1 <= '0;
      c_s2 <= '0;
      c_s3 <= '0;
    end else begin
      c_s1 <= cond;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
    end
  end

  // sync stages two and three must agree before a level counts
  function automatic logic agree(input logic a, input logic b,
                                 input logic old);
    agree = (a == b) ? a : old;
  endfunction

  always_comb begin
    logic cs_f;
    logic sleep_f;
    logic cs_rise;
    cs_f = 1'b1;
    sleep_f = 1'b0;
    cs_rise = 1'b0;
    next_st = st;
    next_st.cs_sync = {st.cs_sync[1:0], cs_n};
    next_st.sleep_sync = {st.sleep_sync[1:0], sleep};
    cs_f = agree(st.cs_sync[1], st.cs_sync[2], st.cs_prev);
    sleep_f = (st.sleep_sync[1] == st.sleep_sync[2]) ? st.sleep_sync[2]
              : 1'b0;
    next_st.cs_prev = cs_f;
    cs_rise = cs_f & ~st.cs_prev & xfer_ok;
    for (int n = 0; n < 2; n++) begin
      logic cin;
      logic sg;
      logic ol;
      logic uc;
      logic l1;
      logic l2;
      logic ot;
      logic cond_any;
      logic [`DSFD_CNT_W-1:0] off_lim;
      cin = 1'b0;
      sg = agree(c_s2[n].short_ground, c_s3[n].short_ground, 1'b0);
      ol = agree(c_s2[n].open_load, c_s3[n].open_load, 1'b0);
      uc = agree(c_s2[n].under_current, c_s3[n].under_current, 1'b0);
      l1 = agree(c_s2[n].limit1, c_s3[n].limit1, 1'b0);
      l2 = agree(c_s2[n].limit2, c_s3[n].limit2, 1'b0);
      ot = agree(c_s2[n].overtemp, c_s3[n].overtemp, 1'b0);
      next_st.ch[n].in_sync = {st.ch[n].in_sync[1:0], ctrl_in[n]};
      cin = agree(st.ch[n].in_sync[1], st.ch[n].in_sync[2], st.ch[n].in_f);
      next_st.ch[n].in_f = cin;
      next_st.ch[n].in_prev = cin;
      cond_any = sg | ol | uc | l1;
      // filter restarts whenever the condition drops
      if (!cond_any) begin
        next_st.ch[n].fcnt = '0;
        next_st.ch[n].fault = 1'b0;
      end else if (st.ch[n].fcnt >= FAULT_CYC - 1'b1) begin
        next_st.ch[n].fault = 1'b1;
      end else begin
        next_st.ch[n].fcnt = st.ch[n].fcnt + 1'b1;
      end
      // second limit: switch-off delay depends on slew rate
      off_lim = slew_sel[n] ? OFF_SR2_CYC : OFF_SR1_CYC;
      if (!l2) begin
        next_st.ch[n].ocnt = '0;
      end else if (st.ch[n].ocnt >= off_lim - 1'b1) begin
        next_st.ch[n].lim2_off = 1'b1;
      end else begin
        next_st.ch[n].ocnt = st.ch[n].ocnt + 1'b1;
      end
      // overtemp shutdown latch clears on input falling edge only
      if (ot && ot_latch_mode[n]) begin
        next_st.ch[n].ot_latch = 1'b1;
      end else if (st.ch[n].in_prev && !cin) begin
        next_st.ch[n].ot_latch = 1'b0;
      end
      // overload latch-off also released by turning the channel off
      if (st.ch[n].in_prev && !cin && !l2) begin
        next_st.ch[n].lim2_off = 1'b0;
      end
      // output gate: first limit keeps it on overtemp unfiltered
      next_st.ch[n].out_on = cin & ~spi_off[n] & ~ot & ~st.ch[n].ot_latch
                             & ~st.ch[n].lim2_off & ~sleep_f;
      // latched flags; a set in the clearing cycle wins
      if (cs_rise) begin
        next_st.ch[n].flags.current_limit_flag = 1'b0;
        next_st.ch[n].flags.open_load_flag = 1'b0;
        next_st.ch[n].flags.under_current_flag = 1'b0;
        next_st.ch[n].flags.short_ground_flag = 1'b0;
        // latching mode keeps overtemp flag until channel is off
        if (!ot_latch_mode[n] || !cin || spi_off[n]) begin
          next_st.ch[n].flags.overtemp_flag = 1'b0;
        end
      end
      if (status_diag_mode && !ot) begin
        next_st.ch[n].flags.overtemp_flag = 1'b0;
      end
      if (st.ch[n].fault) begin
        if (sg) next_st.ch[n].flags.short_ground_flag = 1'b1;
        if (ol) next_st.ch[n].flags.open_load_flag = 1'b1;
        if (uc) next_st.ch[n].flags.under_current_flag = 1'b1;
        if (l1) next_st.ch[n].flags.current_limit_flag = 1'b1;
      end
      if (st.ch[n].lim2_off) begin
        next_st.ch[n].flags.current_limit_flag = 1'b1;
      end
      if (ot) begin
        next_st.ch[n].flags.overtemp_flag = 1'b1;
      end
      // protective flag merges limit and temperature
      next_st.ch[n].flags.protective_diag_flag =
        next_st.ch[n].flags.current_limit_flag |
        next_st.ch[n].flags.overtemp_flag;
      // diagnosis code, protection outranks load faults
      if (next_st.ch[n].flags.protective_diag_flag) begin
        next_st.ch[n].code = `DSFD_CODE_PROT;
      end else if (next_st.ch[n].flags.short_ground_flag) begin
        next_st.ch[n].code = cin ? `DSFD_CODE_LOAD : `DSFD_CODE_SG_OFF;
      end else if (next_st.ch[n].flags.open_load_flag |
                   next_st.ch[n].flags.under_current_flag) begin
        next_st.ch[n].code = `DSFD_CODE_LOAD;
      end else begin
        next_st.ch[n].code = `DSFD_CODE_NORMAL;
      end
      // status pin: protective events always low, else follow or invert
      if (sleep_f) begin
        next_st.ch[n].status = 1'b0;
      end else if (ot || st.ch[n].ot_latch || st.ch[n].lim2_off ||
                   (st.ch[n].fault && l1)) begin
        next_st.ch[n].status = 1'b0;
      end else if (st.ch[n].fault) begin
        next_st.ch[n].status = ~cin;
      end else begin
        next_st.ch[n].status = cin;
      end
    end
    // fault pin low while any latched flag stands, released in sleep
    next_st.fault_n = sleep_f |
      ~(|{next_st.ch[0].flags, next_st.ch[1].flags});
    // sense source: one channel or the sum of both
    next_st.sense_en = sense_on & ~sleep_f;
    if (!sense_on) begin
      next_st.sense_mux = 2'h0;
    end else if (sense_sum) begin
      next_st.sense_mux = 2'h3;
    end else begin
      next_st.sense_mux = sense_ch ? 2'h2 : 2'h1;
    end
  end

  // cs and sleep synchronisers reset to idle levels
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.cs_sync <= 3'h7;
      st.cs_prev <= 1'b1;
      st.fault_n <= 1'b1;
      st.ch[0].code <= `DSFD_CODE_NORMAL;
      st.ch[1].code <= `DSFD_CODE_NORMAL;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign out_on = {st.ch[1].out_on, st.ch[0].out_on};
  assign channel_status_pin = {st.ch[1].status, st.ch[0].status};
  assign fault_n = st.fault_n;
  assign flags = {st.ch[1].flags, st.ch[0].flags};
  assign diag_code = {st.ch[1].code, st.ch[0].code};
  assign sense_current_source = st.sense_en;
  assign sense_mux = st.sense_mux;

endmodule

// *** dsfd_defines.svh ***
// timing counts and reset values for the dual-switch fault diagnosis block
// assumes a 125 MHz system clock; all counts are derived from microseconds
`ifndef DSFD_DEFINES_SVH
`define DSFD_DEFINES_SVH

`define DSFD_CLK_MHZ 125
// fault filtering time, nominal figure in microseconds
`define DSFD_T_FAULT_US 100
`define DSFD_FAULT_CYC (`DSFD_T_FAULT_US * `DSFD_CLK_MHZ)
// switch-off delay at the second current limit, per slew rate, microseconds
`define DSFD_T_OFF_SR1_US 50
`define DSFD_T_OFF_SR2_US 150
`define DSFD_T_OFF_MIN_US 10
`define DSFD_OFF_SR1_CYC (`DSFD_T_OFF_SR1_US * `DSFD_CLK_MHZ)
`define DSFD_OFF_SR2_CYC (`DSFD_T_OFF_SR2_US * `DSFD_CLK_MHZ)
`define DSFD_CNT_W 16
// diagnosis codes, msb then lsb
`define DSFD_CODE_NORMAL 2'h3
`define DSFD_CODE_SG_OFF 2'h0
`define DSFD_CODE_LOAD 2'h1
`define DSFD_CODE_PROT 2'h2

`endif

// *** dsfd_pkg.sv ***
// types for the dual-switch fault diagnosis block
// assumes dsfd_defines.svh supplies the counter width
`include "dsfd_defines.svh"

package dsfd_pkg;

  // raw analog comparator conditions for one channel
  typedef struct packed {
    logic short_ground;  // output below short-to-ground threshold
    logic open_load;     // off-state open load
    logic under_current; // on-state under current
    logic limit1;        // current at first limit
    logic limit2;        // current beyond second limit
    logic overtemp;      // channel overtemperature
  } dsfd_cond_t;

  // latched flags of one channel
  typedef struct packed {
    logic current_limit_flag;
    logic overtemp_flag;
    logic protective_diag_flag;
    logic open_load_flag;
    logic under_current_flag;
    logic short_ground_flag;
  } dsfd_flags_t;

  // per-channel live state
  typedef struct packed {
    logic [2:0] in_sync;          // control input synchroniser
    logic [`DSFD_CNT_W-1:0] fcnt; // fault filter counter
    logic [`DSFD_CNT_W-1:0] ocnt; // switch-off delay counter
    logic fault;                  // filtered fault recognised
    logic lim2_off;               // overload latch-off
    logic ot_latch;               // overtemperature shutdown latch
    logic in_prev;                // previous filtered input
    logic in_f;                   // filtered input
    dsfd_flags_t flags;           // latched diagnosis
    logic [1:0] code;             // diagnosis bits
    logic status;                 // status pin
    logic out_on;                 // power output gate
  } dsfd_ch_t;

  typedef struct packed {
    dsfd_ch_t [1:0] ch;
    logic [2:0] cs_sync;          // chip-select synchroniser
    logic cs_prev;
    logic fault_n;                // shared fault pin
    logic sense_en;               // sense source active
    logic [1:0] sense_mux;        // channel weights into sense source
    logic [2:0] sleep_sync;
  } dsfd_state_t;

endpackage

// *** dsfd_diag_assertions.sv ***
// concurrent checks on the ports of the fault diagnosis block
// assumes one clock domain and the shortened filter counts of the bench
`timescale 1ns/100ps

module dsfd_diag_chk #(
  parameter logic [15:0] FAULT_CYC = 16'h0008,
  parameter logic [15:0] OFF_SR1_CYC = 16'h0004,
  parameter logic [15:0] OFF_SR2_CYC = 16'h0006
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [1:0] ctrl_in, // control inputs
  input wire dsfd_pkg::dsfd_cond_t [1:0] cond, // raw conditions
  input wire logic sleep, // sleep request
  input wire logic sense_on, // sense enable
  input wire logic sense_ch, // sense channel
  input wire logic sense_sum, // sense sum select
  input wire logic [1:0] out_on, // output gates
  input wire logic [1:0] channel_status_pin, // status pins
  input wire logic fault_n, // fault pin, active low
  input wire dsfd_pkg::dsfd_flags_t [1:0] flags, // latched flags
  input wire logic sense_current_source, // sense source active
  input wire logic [1:0] sense_mux // channels in sense source
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // windows allow for the three-flop pin synchronisers
  a_sleep_quiet: assert property (sleep [*8] |-> channel_status_pin == 2'h0
    && out_on == 2'h0 && fault_n) else $error("sleep not quiet");
  a_fault_flags: assert property (!fault_n |-> flags != 12'h000)
    else $error("fault pin low with no flag");
  a_prot_merge: assert property ((flags[0].current_limit_flag
    || flags[0].overtemp_flag) |-> ##[0:1] flags[0].protective_diag_flag)
    else $error("protective flag not merged");
  a_sense_off: assert property (!sense_on [*4] |-> !sense_current_source)
    else $error("sense source active while off");
  a_sense_sum: assert property ((sense_on && sense_sum) [*4]
    |-> sense_mux == 2'h3) else $error("sum not selected");
  a_sense_one: assert property ((sense_on && !sense_sum && sense_ch) [*4]
    |-> sense_mux == 2'h2 && sense_current_source)
    else $error("single channel not selected");
  a_filter_len: assert property ($rose(flags[0].open_load_flag)
    |-> $past(cond[0].open_load, 6)) else $error("flag set unfiltered");
  a_lim2_cut: assert property (cond[1].limit2 [*8] |-> ##[0:6] !out_on[1])
    else $error("overload not switched off");
  a_status_follow: assert property ((ctrl_in[0] && cond[0] == 6'h00
    && !sleep) [*8] |-> channel_status_pin[0])
    else $error("status not following input");
endmodule

// *** dsfd_mcu.sv ***
// controller model: one read frame of the diagnosis flags per request
// assumes the device clears flags a few cycles after chip select rises
`timescale 1ns/100ps

module dsfd_mcu (
  input wire logic clk_sys, // system clock
  input wire logic go, // start one frame
  input wire dsfd_pkg::dsfd_flags_t [1:0] flags, // device flags
  output logic cs_n, // chip select, active low
  output logic xfer_ok, // frame well formed
  output dsfd_pkg::dsfd_flags_t [1:0] snap, // flags read in frame
  output logic busy // frame in progress
);
  // xfer_ok is held past the rise so the synced edge still sees it
  initial begin
    cs_n = 1'b1;
    xfer_ok = 1'b0;
    busy = 1'b0;
    snap = '0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        #1 busy = 1'b1;
        cs_n = 1'b0;
        xfer_ok = 1'b1;
        repeat (6) @(posedge clk_sys);
        snap = flags; // read before the clearing edge
        #1 cs_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 xfer_ok = 1'b0;
        busy = 1'b0;
      end
    end
  end
endmodule

// *** dsfd_diag_tb.sv ***
// self-checking bench for the fault diagnosis block
// assumes shortened counts: filter 8, switch-off 4 and 6 cycles
`timescale 1ns/100ps

module dsfd_diag_tb;
  logic clk_sys, arst_n, sleep, cs_n, xfer_ok, go, busy;
  logic [1:0] ctrl_in, spi_off, ot_latch_mode, slew_sel, out_on, st;
  logic status_diag_mode, sense_on, sense_ch, sense_sum, fault_n, src;
  logic [1:0] sense_mux;
  logic [3:0] diag_code;
  dsfd_pkg::dsfd_cond_t [1:0] cond;
  dsfd_pkg::dsfd_flags_t [1:0] flags, snap;
  int miscompares, n_checks;

  dsfd_diag #(.FAULT_CYC(16'h0008), .OFF_SR1_CYC(16'h0004),
    .OFF_SR2_CYC(16'h0006)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .ctrl_in(ctrl_in), .cond(cond), .sleep(sleep), .cs_n(cs_n),
    .xfer_ok(xfer_ok), .spi_off(spi_off), .ot_latch_mode(ot_latch_mode),
    .slew_sel(slew_sel), .status_diag_mode(status_diag_mode),
    .sense_on(sense_on), .sense_ch(sense_ch), .sense_sum(sense_sum),
    .out_on(out_on), .channel_status_pin(st), .fault_n(fault_n),
    .flags(flags), .diag_code(diag_code), .sense_current_source(src),
    .sense_mux(sense_mux));
  dsfd_mcu mcu_u (.clk_sys(clk_sys), .go(go), .flags(flags), .cs_n(cs_n),
    .xfer_ok(xfer_ok), .snap(snap), .busy(busy));

  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input logic [5:0] g, input logic [5:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one controller frame, waited on with a bound
  task automatic rd;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(2);
    repeat (20) if (busy) cyc(1);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    finish_test;
  end

  initial begin
    {ctrl_in, cond, sleep, go, spi_off, ot_latch_mode, slew_sel} = '0;
    {status_diag_mode, sense_on, sense_ch, sense_sum} = '0;
    arst_n = 1'b0;
    cyc(12);
    arst_n = 1'b1;
    ctrl_in = 2'h3;
    cyc(8);
    chk(6'(st), 6'h03);
    chk(6'(diag_code), 6'h0F);
    cond[0].open_load = 1'b1;
    cyc(4);
    cond[0].open_load = 1'b0;
    cyc(16);
    chk(flags[0], 6'h00);
    cond[0].open_load = 1'b1;
    cyc(14);
    chk(6'(st), 6'h02);
    chk(flags[0], 6'h04);
    chk(6'({fault_n, diag_code[1:0]}), 6'h01);
    cond[0].open_load = 1'b0;
    cyc(8);
    chk(6'(st), 6'h03);
    chk(flags[0], 6'h04);
    rd();
    chk(snap[0], 6'h04);
    chk(6'({fault_n, flags[0]}), 6'h40);
    $display("load test done");
    for (int i = 0; i < 2; i++) begin
      ctrl_in[1] = 1'(i);
      cond[1].short_ground = 1'b1;
      cyc(14);
      chk(6'({st[1], diag_code[3:2]}), 6'(4 * (1 - i) + i));
      cond[1].short_ground = 1'b0;
      rd();
    end
    cond[0].limit1 = 1'b1;
    cyc(14);
    chk(flags[0], 6'h28);
    chk(6'({out_on[0], st[0], fault_n, diag_code[1:0]}), 6'h12);
    cond[0].limit1 = 1'b0;
    rd();
    slew_sel = 2'h2;
    cond[1].limit2 = 1'b1;
    cyc(3);
    cond[1].limit2 = 1'b0;
    cyc(12);
    chk(6'(out_on), 6'h03);
    cond[1].limit2 = 1'b1;
    cyc(12);
    chk(6'({out_on[1], st[1], diag_code[3:2]}), 6'h02);
    cond[1].limit2 = 1'b0;
    cyc(8);
    chk(6'(out_on[1]), 6'h00);
    ctrl_in[1] = 1'b0;
    cyc(6);
    ctrl_in[1] = 1'b1;
    cyc(8);
    chk(6'(out_on[1]), 6'h01);
    rd();
    $display("overload test done");
    cond[0].overtemp = 1'b1;
    cyc(6);
    chk(6'({out_on[0], diag_code[1:0]}), 6'h02);
    chk(flags[0], 6'h18);
    cond[0].overtemp = 1'b0;
    cyc(8);
    chk(6'(out_on[0]), 6'h01);
    rd();
    ot_latch_mode = 2'h2;
    cond[1].overtemp = 1'b1;
    cyc(6);
    cond[1].overtemp = 1'b0;
    cyc(8);
    chk(6'(out_on[1]), 6'h00);
    rd();
    chk(6'(flags[1].overtemp_flag), 6'h01);
    ctrl_in[1] = 1'b0;
    cyc(6);
    rd();
    chk(6'(flags[1].overtemp_flag), 6'h00);
    ctrl_in[1] = 1'b1;
    cyc(8);
    chk(6'(out_on[1]), 6'h01);
    status_diag_mode = 1'b1;
    cond[0].overtemp = 1'b1;
    cyc(6);
    cond[0].overtemp = 1'b0;
    cyc(6);
    chk(6'(flags[0].overtemp_flag), 6'h00);
    status_diag_mode = 1'b0;
    rd();
    $display("overtemp test done");
    spi_off = 2'h1;
    cyc(4);
    chk(6'(out_on), 6'h02);
    spi_off = 2'h0;
    cyc(4);
    chk(6'(out_on), 6'h03);
    for (int i = 0; i < 8; i++) begin
      {sense_on, sense_sum, sense_ch} = 3'(i);
      cyc(4);
      chk(6'(src), 6'(i / 4));
      if (i >= 4) chk(6'(sense_mux), i[1] ? 6'h03 : 6'(1 + i % 2));
    end
    sleep = 1'b1;
    cyc(8);
    chk(6'({out_on, st, fault_n}), 6'h01);
    $display("sense and sleep test done");
    finish_test;
  end
endmodule

bind dsfd_diag dsfd_diag_chk #(.FAULT_CYC(FAULT_CYC),
  .OFF_SR1_CYC(OFF_SR1_CYC), .OFF_SR2_CYC(OFF_SR2_CYC)) chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .ctrl_in(ctrl_in), .cond(cond),
  .sleep(sleep), .sense_on(sense_on), .sense_ch(sense_ch),
  .sense_sum(sense_sum), .out_on(out_on),
  .channel_status_pin(channel_status_pin), .fault_n(fault_n),
  .flags(flags), .sense_current_source(sense_current_source),
  .sense_mux(sense_mux));
